// ===== src/led_slot_pkg.sv
/*
 * Package for the LED slot pulse timing block: register offsets, field
 * positions, reset values and microsecond timing constants.
 * Assumes a 20 MHz system clock and a simple register port.
 */
package led_slot_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    localparam logic [7:0] FINE_CURRENT_OFS = 8'h25;
    localparam logic [7:0] SLOT_A_SHAPE_OFS = 8'h30;
    localparam logic [7:0] SLOT_A_TRAIN_OFS = 8'h31;
    localparam logic [7:0] LED_DISABLE_OFS = 8'h34;
    localparam logic [7:0] SLOT_B_SHAPE_OFS = 8'h35;
    localparam logic [7:0] SLOT_B_TRAIN_OFS = 8'h36;

    localparam int THIRD_FINE_LSB = 11;
    localparam int SECOND_FINE_LSB = 6;
    localparam int FIRST_FINE_LSB = 0;
    localparam int WIDTH_LSB = 8;
    localparam int OFFSET_LSB = 0;
    localparam int COUNT_LSB = 8;
    localparam int PERIOD_LSB = 0;
    localparam int SLOT_B_OFF_BIT = 9;
    localparam int SLOT_A_OFF_BIT = 8;

    localparam logic [4:0] FINE_CODE_RST = 5'h0C;
    localparam logic [4:0] PULSE_WIDTH_RST = 5'h03;
    localparam logic [7:0] PULSE_OFFSET_RST = 8'h20;
    localparam logic [7:0] PULSE_COUNT_RST = 8'h08;
    localparam logic [7:0] PULSE_PERIOD_RST = 8'h18;

    // Writable bits of each register; reserved bits read as zero
    localparam logic [15:0] FINE_CURRENT_MASK = 16'hFFDF;
    localparam logic [15:0] SHAPE_MASK = 16'h1FFF;
    localparam logic [15:0] TRAIN_MASK = 16'hFFFF;
    localparam logic [15:0] DISABLE_MASK = 16'h0300;

    localparam int CLK_FREQ_HZ = 20000000;
    localparam int STEP_TIME_NS = 1000;
    localparam int STEP_CYCLES_INT = (STEP_TIME_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
    localparam logic [4:0] STEP_CYCLES = 5'(STEP_CYCLES_INT);
endpackage : led_slot_pkg

// ===== src/slot_pulse_engine.sv
/*
 * One time slot's pulse train: waits the offset, then emits count pulses of
 * the given width, started every period. Advances on a 1 us tick.
 * Assumes settings are stable while a slot runs.
 */
module slot_pulse_engine
    import led_slot_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic us_tick_in,
    input wire logic start_in,
    input wire logic led_off_in,
    input wire logic [4:0] width_in,
    input wire logic [7:0] offset_in,
    input wire logic [7:0] count_in,
    input wire logic [7:0] period_in,
    output logic pulse_out,
    output logic busy_out
);
    typedef enum logic [1:0] {IDLE, OFFSET, TRAIN} eng_state_t;
    eng_state_t state_q;
    logic [7:0] tmr_q;
    logic [7:0] left_q;
    logic pulse_q;

    // Pulse level within the period
    wire in_width = tmr_q < {3'h0, width_in};
    wire period_end = (tmr_q + 8'h01) >= period_in;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_q <= IDLE;
            tmr_q <= 8'h00;
            left_q <= 8'h00;
            pulse_q <= 1'b0;
        end else begin
            case (state_q)
                IDLE: begin
                    pulse_q <= 1'b0;
                    if (start_in && count_in != 8'h00) begin
                        state_q <= OFFSET;
                        tmr_q <= 8'h00;
                        left_q <= count_in;
                    end
                end
                OFFSET: begin
                    if (tmr_q >= offset_in) begin
                        state_q <= TRAIN;
                        tmr_q <= 8'h00;
                    end else if (us_tick_in) begin
                        tmr_q <= tmr_q + 8'h01;
                    end
                end
                TRAIN: begin
                    // Disable only gates current; timing keeps running
                    pulse_q <= in_width && !led_off_in;
                    if (us_tick_in) begin
                        if (period_end || !in_width && left_q == 8'h01) begin
                            tmr_q <= 8'h00;
                            left_q <= left_q - 8'h01;
                            if (left_q == 8'h01) begin
                                state_q <= IDLE;
                                // Cut the pulse with the train so it never outlives busy
                                pulse_q <= 1'b0;
                            end
                        end else begin
                            tmr_q <= tmr_q + 8'h01;
                        end
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end

    assign pulse_out = pulse_q;
    assign busy_out = state_q != IDLE;
endmodule : slot_pulse_engine

// ===== src/led_slot_pulse_timing.sv
/*
 * LED pulse timing for slots A and B plus fine current codes for three
 * drivers, reached over a simple addressed register port (one cycle write,
 * registered read). Assumes slot starts come from the sequencer on sys_clk_in.
 */
module led_slot_pulse_timing
    import led_slot_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic slot_a_start_in,
    input wire logic slot_b_start_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic slot_a_pulse_out,
    output logic slot_b_pulse_out,
    output logic slot_a_busy_out,
    output logic slot_b_busy_out,
    output logic [4:0] first_driver_fine_code_out,
    output logic [4:0] second_driver_fine_code_out,
    output logic [4:0] third_driver_fine_code_out
);
    logic [15:0] led_fine_current_q;
    logic [15:0] slot_a_pulse_shape_q;
    logic [15:0] slot_a_pulse_train_q;
    logic [15:0] slot_led_disable_q;
    logic [15:0] slot_b_pulse_shape_q;
    logic [15:0] slot_b_pulse_train_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic [4:0] tick_cnt_q;
    logic us_tick_q;
    logic a_pulse_w, b_pulse_w, a_busy_w, b_busy_w;
    logic a_pulse_q, b_pulse_q, a_busy_q, b_busy_q;

    wire sel_fine = reg_addr_in == FINE_CURRENT_OFS;
    wire sel_a_shape = reg_addr_in == SLOT_A_SHAPE_OFS;
    wire sel_a_train = reg_addr_in == SLOT_A_TRAIN_OFS;
    wire sel_dis = reg_addr_in == LED_DISABLE_OFS;
    wire sel_b_shape = reg_addr_in == SLOT_B_SHAPE_OFS;
    wire sel_b_train = reg_addr_in == SLOT_B_TRAIN_OFS;

    // Reset images built from field constants
    // Widen before shifting so no field bit is lost
    wire [15:0] fine_rst = (16'(FINE_CODE_RST) << THIRD_FINE_LSB) | (16'(FINE_CODE_RST) << SECOND_FINE_LSB)
                           | (16'(FINE_CODE_RST) << FIRST_FINE_LSB);
    wire [15:0] shape_rst = (16'(PULSE_WIDTH_RST) << WIDTH_LSB) | (16'(PULSE_OFFSET_RST) << OFFSET_LSB);
    wire [15:0] train_rst = (16'(PULSE_COUNT_RST) << COUNT_LSB) | (16'(PULSE_PERIOD_RST) << PERIOD_LSB);

    logic [15:0] rd_mux;
    always_comb begin
        if (sel_fine) rd_mux = led_fine_current_q;
        else if (sel_a_shape) rd_mux = slot_a_pulse_shape_q;
        else if (sel_a_train) rd_mux = slot_a_pulse_train_q;
        else if (sel_dis) rd_mux = slot_led_disable_q;
        else if (sel_b_shape) rd_mux = slot_b_pulse_shape_q;
        else if (sel_b_train) rd_mux = slot_b_pulse_train_q;
        else rd_mux = 16'h0000;
    end

    // Registers; reserved bits are held at zero whatever is written
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            led_fine_current_q <= fine_rst;
            slot_a_pulse_shape_q <= shape_rst;
            slot_a_pulse_train_q <= train_rst;
            slot_led_disable_q <= 16'h0000;
            slot_b_pulse_shape_q <= shape_rst;
            slot_b_pulse_train_q <= train_rst;
        end else if (reg_wr_in) begin
            if (sel_fine) led_fine_current_q <= reg_wdata_in & FINE_CURRENT_MASK;
            if (sel_a_shape) slot_a_pulse_shape_q <= reg_wdata_in & SHAPE_MASK;
            if (sel_a_train) slot_a_pulse_train_q <= reg_wdata_in & TRAIN_MASK;
            if (sel_dis) slot_led_disable_q <= reg_wdata_in & DISABLE_MASK;
            if (sel_b_shape) slot_b_pulse_shape_q <= reg_wdata_in & SHAPE_MASK;
            if (sel_b_train) slot_b_pulse_train_q <= reg_wdata_in & TRAIN_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
            rvalid_q <= reg_rd_in;
        end
    end

    // One microsecond timebase
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            tick_cnt_q <= 5'h00;
            us_tick_q <= 1'b0;
        end else begin
            us_tick_q <= tick_cnt_q == STEP_CYCLES - 5'h01;
            tick_cnt_q <= (tick_cnt_q == STEP_CYCLES - 5'h01) ? 5'h00 : tick_cnt_q + 5'h01;
        end
    end

    slot_pulse_engine u_slot_a (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .us_tick_in(us_tick_q),
        .start_in(slot_a_start_in),
        .led_off_in(slot_led_disable_q[SLOT_A_OFF_BIT]),
        .width_in(slot_a_pulse_shape_q[WIDTH_LSB +: 5]),
        .offset_in(slot_a_pulse_shape_q[OFFSET_LSB +: 8]),
        .count_in(slot_a_pulse_train_q[COUNT_LSB +: 8]),
        .period_in(slot_a_pulse_train_q[PERIOD_LSB +: 8]),
        .pulse_out(a_pulse_w),
        .busy_out(a_busy_w)
    );

    slot_pulse_engine u_slot_b (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .us_tick_in(us_tick_q),
        .start_in(slot_b_start_in),
        .led_off_in(slot_led_disable_q[SLOT_B_OFF_BIT]),
        .width_in(slot_b_pulse_shape_q[WIDTH_LSB +: 5]),
        .offset_in(slot_b_pulse_shape_q[OFFSET_LSB +: 8]),
        .count_in(slot_b_pulse_train_q[COUNT_LSB +: 8]),
        .period_in(slot_b_pulse_train_q[PERIOD_LSB +: 8]),
        .pulse_out(b_pulse_w),
        .busy_out(b_busy_w)
    );

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            a_pulse_q <= 1'b0;
            b_pulse_q <= 1'b0;
            a_busy_q <= 1'b0;
            b_busy_q <= 1'b0;
        end else begin
            a_pulse_q <= a_pulse_w;
            b_pulse_q <= b_pulse_w;
            a_busy_q <= a_busy_w;
            b_busy_q <= b_busy_w;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign slot_a_pulse_out = a_pulse_q;
    assign slot_b_pulse_out = b_pulse_q;
    assign slot_a_busy_out = a_busy_q;
    assign slot_b_busy_out = b_busy_q;
    assign first_driver_fine_code_out = led_fine_current_q[FIRST_FINE_LSB +: 5];
    assign second_driver_fine_code_out = led_fine_current_q[SECOND_FINE_LSB +: 5];
    assign third_driver_fine_code_out = led_fine_current_q[THIRD_FINE_LSB +: 5];
endmodule : led_slot_pulse_timing

// ===== dv/led_driver_model.sv
/* LED driver stage seen from the pulse line: counts pulses, last high time, last rise-to-rise gap.
   Assumes the pulse line is a registered level on sys_clk_in; clear_in zeroes the three outputs, not the internal run and gap counters. */
module led_driver_model (
    input wire logic sys_clk_in,
    input wire logic drive_in,
    input wire logic clear_in,
    output logic [7:0] pulse_count_out,
    output logic [15:0] high_cycles_out,
    output logic [15:0] gap_cycles_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q = 1'b0;
    logic [15:0] run_q = 16'h0000;
    logic [15:0] since_q = 16'h0000;
    // Measures width, period and count of each train
    always @(posedge sys_clk_in) begin
        last_q <= drive_in;
        since_q <= since_q + 16'h0001;
        if (drive_in) run_q <= run_q + 16'h0001;
        if (drive_in && !last_q) begin
            pulse_count_out <= pulse_count_out + 8'h01;
            gap_cycles_out <= since_q;
            since_q <= 16'h0001;
            run_q <= 16'h0001;
        end
        if (!drive_in && last_q) high_cycles_out <= run_q;
        if (clear_in) begin
            pulse_count_out <= 8'h00;
            high_cycles_out <= 16'h0000;
            gap_cycles_out <= 16'h0000;
        end
    end
endmodule : led_driver_model

// ===== dv/led_slot_pulse_timing_properties.sv
/* Port checker for the LED slot pulse timing block.
   Assumes it is bound to the top module and sees its ports only. */
module led_slot_checker
    import led_slot_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic slot_a_pulse_out,
    input wire logic slot_b_pulse_out,
    input wire logic slot_a_busy_out,
    input wire logic slot_b_busy_out,
    input wire logic [4:0] first_driver_fine_code_out,
    input wire logic [4:0] second_driver_fine_code_out,
    input wire logic [4:0] third_driver_fine_code_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic mapped = reg_addr_in inside {FINE_CURRENT_OFS, SLOT_A_SHAPE_OFS, SLOT_A_TRAIN_OFS,
        LED_DISABLE_OFS, SLOT_B_SHAPE_OFS, SLOT_B_TRAIN_OFS};
    wire logic fine_sel = reg_addr_in == FINE_CURRENT_OFS;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_no_stray_valid: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("valid without read");
    a_idle_data_zero: assert property (!reg_rvalid_out |-> reg_rdata_out == 16'h0000)
        else $error("read data not zero when idle");
    a_unmapped_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_fine_code_write: assert property (reg_wr_in && fine_sel |=>
        {third_driver_fine_code_out, second_driver_fine_code_out, first_driver_fine_code_out} ==
        {$past(reg_wdata_in[15:11]), $past(reg_wdata_in[10:6]), $past(reg_wdata_in[4:0])})
        else $error("fine codes not taken from write");
    a_fine_readback: assert property (reg_rd_in && !reg_wr_in && fine_sel |=>
        reg_rdata_out == {third_driver_fine_code_out, second_driver_fine_code_out, 1'b0,
        first_driver_fine_code_out}) else $error("fine readback differs from codes");
    a_reset_quiet: assert property ($rose(rst_n_in) |-> first_driver_fine_code_out == FINE_CODE_RST &&
        second_driver_fine_code_out == FINE_CODE_RST && third_driver_fine_code_out == FINE_CODE_RST &&
        !slot_a_busy_out && !slot_b_busy_out) else $error("reset state wrong");
    a_a_pulse_bounded: assert property (slot_a_pulse_out |-> slot_a_busy_out)
        else $error("slot A pulse outside slot");
    a_b_pulse_bounded: assert property (slot_b_pulse_out |-> slot_b_busy_out)
        else $error("slot B pulse outside slot");
    a_slot_a_holds: assert property ($rose(slot_a_busy_out) |-> slot_a_busy_out [*8])
        else $error("slot A ended too early");
endmodule : led_slot_checker

bind led_slot_pulse_timing led_slot_checker led_slot_checker_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .slot_a_pulse_out(slot_a_pulse_out),
    .slot_b_pulse_out(slot_b_pulse_out), .slot_a_busy_out(slot_a_busy_out), .slot_b_busy_out(slot_b_busy_out),
    .first_driver_fine_code_out(first_driver_fine_code_out),
    .second_driver_fine_code_out(second_driver_fine_code_out),
    .third_driver_fine_code_out(third_driver_fine_code_out));

// ===== dv/led_slot_pulse_timing_test.sv
/* Self-checking bench for the LED slot pulse timing block with two driver models.
   Assumes a 50 ns clock; inputs change 2 ns after each rising edge. */
module led_slot_pulse_timing_test
    import led_slot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 0, rst_n_in = 0, wr = 0, rd = 0, sa = 0, sb = 0, clr = 1;
    logic [7:0] addr = 8'h00, na, nb;
    logic [15:0] wdata = 16'h0000, rdata, ha, hb, ga, gb;
    logic rvalid, pa, pb, ba, bb;
    logic [4:0] c1, c2, c3;
    int failures = 0, compares = 0;
    led_slot_pulse_timing led_slot_pulse_timing_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .slot_a_start_in(sa),
        .slot_b_start_in(sb), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .slot_a_pulse_out(pa),
        .slot_b_pulse_out(pb), .slot_a_busy_out(ba), .slot_b_busy_out(bb),
        .first_driver_fine_code_out(c1), .second_driver_fine_code_out(c2), .third_driver_fine_code_out(c3));
    led_driver_model led_driver_model_i [1:0] (.sys_clk_in(sys_clk_in), .drive_in({pb, pa}),
        .clear_in(clr), .pulse_count_out({nb, na}), .high_cycles_out({hb, ha}), .gap_cycles_out({gb, ga}));
    initial forever #25 sys_clk_in = ~sys_clk_in;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask : tick
    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        tick(1);
        addr = a;
        wdata = d;
        wr = 1;
        tick(1);
        wr = 0;
    endtask : wr_reg
    task rd_chk(input logic [7:0] a, input logic [15:0] exp);
        tick(1);
        addr = a;
        rd = 1;
        tick(1);
        rd = 0;
        chk(rvalid, 1'b1);
        chk(rdata, exp);
    endtask : rd_chk
    // Start the chosen slots and wait, bounded, until both are idle
    task run(input logic [1:0] go, input logic [1:0] exp);
        tick(1);
        {sb, sa} = go;
        clr = 1;
        tick(1);
        {sb, sa} = 2'b00;
        clr = 0;
        tick(2);
        chk({bb, ba}, exp);
        for (int i = 0; i < 4000 && (ba || bb); i++) tick(1);
        chk({bb, ba}, 2'b00);
    endtask : run
    task t_reset;
        rd_chk(8'h25, 16'h630C);
        rd_chk(8'h30, 16'h0320);
        rd_chk(8'h31, 16'h0818);
        rd_chk(8'h34, 16'h0000);
        rd_chk(8'h35, 16'h0320);
        rd_chk(8'h36, 16'h0818);
        rd_chk(8'h33, 16'h0000);
        chk({c3, c2, c1}, {3{5'h0C}});
        $display("test reset done");
    endtask : t_reset
    task t_fine;
        wr_reg(8'h25, 16'hFFDF);
        rd_chk(8'h25, 16'hFFDF);
        wr_reg(8'h25, 16'h5A93);
        tick(1);
        chk({c3, c2, c1}, {5'h0B, 5'h0A, 5'h13});
        $display("test fine done");
    endtask : t_fine
    // Both slots at once with unlike settings; tolerance covers tick jitter
    task t_trains;
        wr_reg(8'h30, 16'h0203);
        wr_reg(8'h31, 16'h0305);
        wr_reg(8'h35, 16'h0101);
        wr_reg(8'h36, 16'h0604);
        rd_chk(8'h30, 16'h0203);
        run(2'b11, 2'b11);
        chk({nb, na}, {8'h06, 8'h03});
        chk(ga >= 80 && ga <= 120, 1'b1);
        chk(gb >= 60 && gb <= 100, 1'b1);
        chk(ha >= 20 && ha <= 60, 1'b1);
        chk(hb >= 1 && hb <= 40, 1'b1);
        $display("test trains done");
    endtask : t_trains
    task t_disable;
        wr_reg(8'h34, 16'h0300);
        rd_chk(8'h34, 16'h0300);
        run(2'b11, 2'b11);
        chk({nb, na}, 16'h0000);
        wr_reg(8'h34, 16'h0200);
        run(2'b11, 2'b11);
        chk({nb, na}, {8'h00, 8'h03});
        wr_reg(8'h34, 16'h0000);
        wr_reg(8'h31, 16'h0005);
        run(2'b01, 2'b00);
        $display("test disable done");
    endtask : t_disable
    task end_of_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge sys_clk_in);
        #2 rst_n_in = 1;
        t_reset;
        t_fine;
        t_trains;
        t_disable;
        end_of_test;
    end
    initial begin
        #2000000;
        failures++;
        end_of_test;
    end
endmodule : led_slot_pulse_timing_test
